// ### test/pbae_bridge_tb.sv
`timescale 1ns/1ps
`include "pbae_map.svh"
module pbae_bridge_tb
    import pbae_pkg::*;
;
    logic clk = 0, rst = 1, reqValid = 0, coreErrIn = 0, slow = 0;
    logic [3:0] present = 4'hF;
    pbae_req_t req = '0;
    logic reqReady, rspValid, perValid, perDone, lockSeen = 0;
    pbae_rsp_t rsp, got;
    pbae_req_t perReq;
    logic [2:0] perSel;
    logic [63:0] perRdata;
    logic [31:0] vclView;
    int num_errors = 0, compares = 0, cycles = 0, perCnt = 0;

    always #5 clk = ~clk;

    pbae_bridge i_pbae_bridge (.clk(clk), .rst(rst), .present(present),
        .reqValid(reqValid), .reqReady(reqReady), .req(req),
        .rspValid(rspValid), .rsp(rsp), .coreErrIn(coreErrIn),
        .perSel(perSel), .perValid(perValid), .perReq(perReq),
        .perDone(perDone), .perRdata(perRdata), .vclView(vclView));
    pbae_per_model i_pbae_per_model (.clk(clk), .rst(rst),
        .perValid(perValid), .perReq(perReq), .slow(slow),
        .perDone(perDone), .perRdata(perRdata));

    task automatic stop_test;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // watchdog, forwarded-cycle count and lock monitor
    always @(posedge clk) begin
        cycles++;
        if (perValid) perCnt++;
        if (perValid && perReq.lock) lockSeen = 1;
        if (cycles == 3000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic chk64(input logic [63:0] g, e, input string m);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t %s %h", $time, m, g);
        end
    endtask

    // one request; waits a bounded time for the single response
    task automatic access(input logic [31:0] a, input logic [7:0] o,
                          input logic [63:0] d, input logic lk);
        int n;
        n = 0;
        @(negedge clk);
        reqValid = 1;
        req = '{addr: a, opc: o, wdata: d, be: 8'hFF, lock: lk};
        chk64(64'(reqReady), 64'h1, "not ready");
        @(negedge clk);
        reqValid = 0;
        req = '{addr: ~a, opc: ~o, wdata: ~d, be: 8'h00, lock: ~lk};
        while (rspValid !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        got = rsp;
        chk64(64'(n < 20), 64'h1, "no response");
    endtask

    task automatic t_reset;
        chk64(64'(vclView), 64'h0, "flags after reset");
    endtask

    // bad address, absent subsystem, bad opcode, doubly bad
    task automatic t_bad;
        logic [31:0] a[4] = '{32'hFFC00100, 32'hFFD80004, 32'hFFD00000, 0};
        logic [7:0] o[4] = '{8'h02, 8'h02, 8'h08, 8'h10};
        logic [3:0] p[4] = '{4'hF, 4'hB, 4'hF, 4'hF};
        logic [31:0] m[4] = '{32'h4, 32'h4, 32'h20, 32'h24};
        int c;
        for (int i = 0; i < 4; i++) begin
            present = p[i];
            access(`PBAE_VCL_ADDR, 8'h06, 64'h0, 0);
            chk64(64'(vclView), 64'h0, "clear flags");
            c = perCnt;
            access(a[i], o[i], 64'h0, 0);
            chk64(64'(got.err), 64'h1, "no error rsp");
            chk64(64'(|(vclView & m[i])), 64'h1, "flag");
            chk64(64'(vclView[1]), 64'h1, "err sent");
            chk64(64'(perCnt == c), 64'h1, "forwarded");
        end
        present = 4'hF;
    endtask

    // all eight legal opcodes, lock set, prompt and slow peripheral
    task automatic t_good;
        logic [31:0] a;
        int c;
        for (int o = 0; o < 8; o++) begin
            a = 32'hFFD00000 + o * 8;
            slow = o[0];
            c = perCnt;
            access(a, 8'(o), 64'h0123456789ABCDEF, 1);
            chk64(64'(got.err), 64'h0, "good rejected");
            chk64(64'(got.lock), 64'h0, "lock in rsp");
            chk64(64'(perCnt > c), 64'h1, "not forwarded");
            if (o < 4)
                chk64(got.rdata, {~a, a}, "rdata");
        end
        chk64(64'(lockSeen), 64'h0, "lock forwarded");
    endtask

    // flag stores, core error input, high register read
    task automatic t_regs;
        access(`PBAE_VCL_ADDR, 8'h06, {2{32'h7}}, 0);
        chk64(64'(vclView), 64'h7, "store ones");
        access(`PBAE_VCL_ADDR, 8'h06, 64'h0, 0);
        chk64(64'(vclView), 64'h0, "store zeros");
        @(negedge clk);
        coreErrIn = 1;
        @(negedge clk);
        coreErrIn = 0;
        chk64(64'(vclView[0]), 64'h1, "err received");
        access(`PBAE_VCH_ADDR, 8'h02, 64'h0, 0);
        chk64(64'(got.rdata[31:0] === `PBAE_VCH_VALUE ||
            got.rdata[63:32] === `PBAE_VCH_VALUE), 64'h1, "high");
    endtask

    initial begin
        repeat (3) @(negedge clk);
        rst = 0;
        t_reset();
        t_bad();
        t_good();
        t_regs();
        stop_test();
    end
endmodule

// ### test/pbae_per_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// peripheral answering forwarded requests
// ----------------------------------------
module pbae_per_model
    import pbae_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request from the bridge
    input wire logic perValid,
    input wire pbae_req_t perReq,
    input wire logic slow,
    // answer
    output logic perDone,
    output logic [63:0] perRdata
);
    logic [2:0] cnt;
    // done after 1 or 5 cycles; restarts when the bridge lets go
    always_ff @(posedge clk) begin
        if (rst || !perValid) begin
            cnt <= 3'h0;
            perDone <= 1'b0;
        end else begin
            cnt <= cnt + 3'h1;
            perDone <= (cnt == (slow ? 3'h4 : 3'h0));
        end
    end
    // data is only valid with done; otherwise show a flipped pattern
    assign perRdata = perDone ? {~perReq.addr, perReq.addr}
                              : {perReq.addr, ~perReq.addr};
endmodule

// ### verilog/pbae_bridge.sv
`timescale 1ns/1ps
`include "pbae_map.svh"
module pbae_bridge
    import pbae_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // build configuration, one bit per subsystem window
    input wire logic [3:0] present,
    // initiator side request
    input wire logic reqValid,
    output logic reqReady,
    input wire pbae_req_t req,
    // initiator side response
    output logic rspValid,
    output pbae_rsp_t rsp,
    // core initiator port saw an error response
    input wire logic coreErrIn,
    // peripheral side
    output logic [2:0] perSel,
    output logic perValid,
    output pbae_req_t perReq,
    input wire logic perDone,
    input wire logic [63:0] perRdata,
    // flag view
    output logic [31:0] vclView
);
    pbae_state_t state;
    logic badAddr, badOpc, isVcr;
    logic [2:0] target;
    logic errRec, errSnt, flagBadAddr, flagBadOpc;
    logic take, vcrWrite;
    logic [31:0] regAddr;

    // ----------------------------------------------------------------
    // classification
    // ----------------------------------------------------------------
    pbae_decode u_dec (
        .addr(req.addr),
        .opc(req.opc),
        .present(present),
        .badAddr(badAddr),
        .badOpc(badOpc),
        .target(target),
        .isVcr(isVcr)
    );

    assign reqReady = (state == PBAE_IDLE);
    assign take = reqValid && reqReady;
    // only four-byte stores are meaningful here; others undefined
    assign vcrWrite = take && !badAddr && !badOpc && isVcr
        && req.opc[2] && req.addr == `PBAE_VCL_ADDR;

    // ----------------------------------------------------------------
    // request sequencing
    // ----------------------------------------------------------------
    // one request in flight keeps the flags and answers in order
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= PBAE_IDLE;
        end else begin
            unique case (state)
                PBAE_IDLE: begin
                    if (take) begin
                        if (badAddr || badOpc) begin
                            state <= PBAE_ERR;
                        end else if (isVcr) begin
                            state <= PBAE_REG;
                        end else begin
                            state <= PBAE_FWD;
                        end
                    end
                end
                PBAE_FWD: begin
                    if (perDone) begin
                        state <= PBAE_IDLE;
                    end
                end
                PBAE_ERR: state <= PBAE_IDLE;
                PBAE_REG: state <= PBAE_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // peripheral forwarding
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            perReq <= '0;
            perSel <= 3'h0;
        end else if (take && !badAddr && !badOpc && !isVcr) begin
            perReq <= req;
            perReq.lock <= 1'b0;
            perSel <= target;
        end
    end
    assign perValid = (state == PBAE_FWD);

    // every taken address is kept so register reads pick the right word
    always_ff @(posedge clk) begin
        if (rst) begin
            regAddr <= 32'h00000000;
        end else if (take) begin
            regAddr <= req.addr;
        end
    end

    // ----------------------------------------------------------------
    // responses
    // ----------------------------------------------------------------
    // lock is never driven back to the initiator
    always_ff @(posedge clk) begin
        if (rst) begin
            rspValid <= 1'b0;
            rsp <= '0;
        end else begin
            rspValid <= 1'b0;
            rsp.lock <= 1'b0;
            if (state == PBAE_ERR) begin
                rspValid <= 1'b1;
                rsp.err <= 1'b1;
                rsp.rdata <= '0;
            end else if (state == PBAE_FWD && perDone) begin
                rspValid <= 1'b1;
                rsp.err <= 1'b0;
                rsp.rdata <= perRdata;
            end else if (state == PBAE_REG) begin
                rspValid <= 1'b1;
                rsp.err <= 1'b0;
                rsp.rdata <= {32'h0, regAddr == `PBAE_VCH_ADDR
                    ? `PBAE_VCH_VALUE : vclView};
            end
        end
    end

    // ----------------------------------------------------------------
    // error flags; hardware set wins over a software store
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            errRec <= 1'b0;
            errSnt <= 1'b0;
            flagBadAddr <= 1'b0;
            flagBadOpc <= 1'b0;
        end else begin
            if (vcrWrite) begin
                errRec <= req.wdata[`PBAE_BIT_RX_ERR];
                errSnt <= req.wdata[`PBAE_BIT_TX_ERR];
                flagBadAddr <= req.wdata[`PBAE_BIT_BAD_ADDR];
                flagBadOpc <= req.wdata[`PBAE_BIT_BAD_OP];
            end
            if (coreErrIn) begin
                errRec <= 1'b1;
            end
            if (state == PBAE_ERR) begin
                errSnt <= 1'b1;
            end
            // both flags set for a doubly bad request
            if (take && badAddr) begin
                flagBadAddr <= 1'b1;
            end
            if (take && badOpc) begin
                flagBadOpc <= 1'b1;
            end
        end
    end

    // reserved bits read as zero
    always_comb begin
        vclView = {`PBAE_MOD_VERS, 16'h0000};
        vclView[`PBAE_BIT_RX_ERR] = errRec;
        vclView[`PBAE_BIT_TX_ERR] = errSnt;
        vclView[`PBAE_BIT_BAD_ADDR] = flagBadAddr;
        vclView[`PBAE_BIT_BAD_OP] = flagBadOpc;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    bad_addr_flag_a: assert property (@(posedge clk) disable iff (rst)
        take && badAddr |=> flagBadAddr)
        else $error("bad address not flagged");
    bad_opcode_flag_flag_a: assert property (@(posedge clk) disable iff (rst)
        take && badOpc |=> flagBadOpc)
        else $error("bad opcode not flagged");
    err_sent_flag_a: assert property (@(posedge clk) disable iff (rst)
        rspValid && rsp.err |-> errSnt)
        else $error("error sent flag missing");
    bad_err_rsp_a: assert property (@(posedge clk) disable iff (rst)
        take && (badAddr || badOpc) |-> ##2 rspValid && rsp.err)
        else $error("no error response");
    no_fwd_bad_a: assert property (@(posedge clk) disable iff (rst)
        take && (badAddr || badOpc) |=> !perValid[*2])
        else $error("bad request forwarded");
    good_fwd_a: assert property (@(posedge clk) disable iff (rst)
        take && !badAddr && !badOpc && !isVcr |=> perValid
        && perSel == $past(target))
        else $error("good request not forwarded");
    no_lock_a: assert property (@(posedge clk) disable iff (rst)
        !rsp.lock && !perReq.lock)
        else $error("lock driven");
    error_received_flag_flag_a: assert property (@(posedge clk) disable iff (rst)
        coreErrIn |=> errRec)
        else $error("received error not flagged");
    flag_store_a: assert property (@(posedge clk) disable iff (rst)
        vcrWrite && !coreErrIn |=> errRec == $past(req.wdata[0]))
        else $error("store not taken");
    bad_opcode_flag_code_a: assert property (@(posedge clk) disable iff (rst)
        badOpc == (req.opc > 8'h07))
        else $error("opcode class wrong");
endmodule

// ### verilog/pbae_decode.sv
`timescale 1ns/1ps
`include "pbae_map.svh"
// address and opcode classification, purely combinational
module pbae_decode
    import pbae_pkg::*;
(
    // request
    input wire logic [31:0] addr,
    input wire logic [7:0] opc,
    input wire logic [3:0] present,
    // classification
    output logic badAddr,
    output logic badOpc,
    output logic [2:0] target,
    output logic isVcr
);
    function automatic logic inWin(input logic [31:0] a,
                                   input logic [31:0] b);
        inWin = (a & `PBAE_WIN_MASK) == b;
    endfunction

    logic [3:0] hit;

    // one window per subsystem; index 3 is the bridge's own pair
    always_comb begin
        hit[0] = inWin(addr, `PBAE_BASE_CLK);
        hit[1] = inWin(addr, `PBAE_BASE_INT);
        hit[2] = inWin(addr, `PBAE_BASE_TMR);
        hit[3] = inWin(addr, `PBAE_BASE_VCR);
        badAddr = ~|(hit & present);
        // upper opcode bits must be zero: only the eight opcodes pass
        badOpc = |opc[7:3];
        target = hit[0] ? 3'h0 : hit[1] ? 3'h1 : hit[2] ? 3'h2 : 3'h3;
        isVcr = hit[3];
    end
endmodule

// ### verilog/pbae_map.svh
`ifndef PBAE_MAP_SVH
`define PBAE_MAP_SVH

// ----------------------------------------------------------------
// register addresses and fields
// ----------------------------------------------------------------
`define PBAE_VCL_ADDR 32'hFFFFFFFC
`define PBAE_VCH_ADDR 32'hFFFFFFF8
`define PBAE_BIT_RX_ERR 0
`define PBAE_BIT_TX_ERR 1
`define PBAE_BIT_BAD_ADDR 2
`define PBAE_BIT_UNSOL 3
`define PBAE_BIT_BAD_OP 5
`define PBAE_MOD_VERS 16'h0000
// high register content; the value is arbitrary
`define PBAE_VCH_VALUE 32'h12345678

// ----------------------------------------------------------------
// subsystem windows
// ----------------------------------------------------------------
`define PBAE_WIN_MASK 32'hFFFFFF00
`define PBAE_BASE_CLK 32'hFFC00000
`define PBAE_BASE_INT 32'hFFD00000
`define PBAE_BASE_TMR 32'hFFD80000
`define PBAE_BASE_VCR 32'hFFFFFF00
`endif

// ### verilog/pbae_pkg.sv
package pbae_pkg;
    typedef enum logic [2:0] {
        PBAE_LD1 = 3'h0,
        PBAE_LD2 = 3'h1,
        PBAE_LD4 = 3'h2,
        PBAE_LD8 = 3'h3,
        PBAE_ST1 = 3'h4,
        PBAE_ST2 = 3'h5,
        PBAE_ST4 = 3'h6,
        PBAE_ST8 = 3'h7
    } pbae_opc_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [7:0] opc;
        logic [63:0] wdata;
        logic [7:0] be;
        logic lock;
    } pbae_req_t;

    typedef struct packed {
        logic [63:0] rdata;
        logic err;
        logic lock;
    } pbae_rsp_t;

    typedef enum logic [1:0] {
        PBAE_IDLE = 2'b00,
        PBAE_FWD = 2'b01,
        PBAE_ERR = 2'b10,
        PBAE_REG = 2'b11
    } pbae_state_t;
endpackage
